// ===== rtl/light_curtain_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module light_curtain_fault_supervisor #(
    parameter longint unsigned RESET_HOLD_CYCLES = curtain_supervisor_pkg::RESET_HOLD_CYC,
    parameter longint unsigned MUTE_WINDOW_CYCLES = curtain_supervisor_pkg::MUTE_WINDOW_CYC,
    parameter longint unsigned FIELD_SIM_CYCLES = curtain_supervisor_pkg::FIELD_SIM_CYC,
    parameter longint unsigned LINK_SIM_CYCLES = curtain_supervisor_pkg::LINK_SIM_CYC,
    parameter longint unsigned TEST_PULSE_CYCLES = curtain_supervisor_pkg::TEST_PULSE_CYC,
    parameter longint unsigned STARTUP_CYCLES = curtain_supervisor_pkg::STARTUP_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sig8_drive,
    input wire logic i_sig8_readback,
    input wire logic i_other_line,
    input wire logic i_field_sel_a,
    input wire logic i_field_sel_b,
    input wire logic i_reset_btn,
    input wire logic [curtain_supervisor_pkg::MODE_W-1:0] i_mode_sel,
    input wire logic i_mode_polarity,
    input wire logic i_chain_enable,
    input wire logic i_chain_a,
    input wire logic i_chain_b,
    input wire logic i_mute_a,
    input wire logic i_mute_b,
    input wire logic i_field_free,
    input wire logic i_beam_cfg_fault,
    input wire logic i_resp_time_exceeded,
    input wire logic i_teach_active,
    input wire logic i_blank_overlap,
    input wire logic i_chan_copy_a_bad,
    input wire logic i_chan_copy_b_bad,
    input wire logic i_internal_fault,
    input wire logic [7:0] i_internal_code,
    output logic o_safety_switch_output_one,
    output logic o_safety_switch_output_two,
    output logic [7:0] o_disp_class,
    output logic [7:0] o_disp_code,
    output logic o_locked,
    output logic o_muting_active
);
    import curtain_supervisor_pkg::*;

    function automatic logic [TIMER_W-1:0] sat_inc(input logic [TIMER_W-1:0] value, input logic run);
        sat_inc = (!run) ? TIMER_ZERO : ((&value) ? value : value + TIMER_ONE);
    endfunction

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    pin_sync_if pins ();

    assign pins.raw = {1'b0, i_mute_b, i_mute_a, i_chain_b, i_chain_a, i_mode_polarity, i_mode_sel,
                       i_reset_btn, i_field_sel_b, i_field_sel_a, i_other_line, i_sig8_readback};

    pin_sync u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .pins(pins.sync_side)
    );

    wire logic readback = pins.synced[PIN_READBACK];
    wire logic other_line = pins.synced[PIN_OTHER_LINE];
    wire logic field_a = pins.synced[PIN_FIELD_SEL_A];
    wire logic field_b = pins.synced[PIN_FIELD_SEL_B];
    wire logic reset_btn = pins.synced[PIN_RESET_BTN];
    wire logic [MODE_W-1:0] mode_now = pins.synced[PIN_MODE_HI:PIN_MODE_LO];
    wire logic mode_pol = pins.synced[PIN_MODE_POL];
    wire logic chain_a = pins.synced[PIN_CHAIN_A];
    wire logic chain_b = pins.synced[PIN_CHAIN_B];
    wire logic mute_a = pins.synced[PIN_MUTE_A];
    wire logic mute_b = pins.synced[PIN_MUTE_B];

    // ************************************************************
    // signal line read-back
    // ************************************************************
    // drive is delayed to match the read-back synchroniser latency
    logic [1:0] drive_dly;
    logic readback_prev;
    logic other_prev;
    logic e24;
    wire logic drive_match = drive_dly[1];
    wire logic mismatch8 = drive_match != readback;
    wire logic coupled8 = (readback != readback_prev) && (other_line != other_prev)
                          && (drive_dly[1] == drive_dly[0]);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            drive_dly <= 2'h0;
            readback_prev <= 1'b0;
            other_prev <= 1'b0;
            e24 <= 1'b0;
        end else begin
            drive_dly <= {drive_dly[0], i_sig8_drive};
            readback_prev <= readback;
            other_prev <= other_line;
            e24 <= mismatch8 || coupled8;
        end
    end

    // ************************************************************
    // timers
    // ************************************************************
    logic [TIMER_W-1:0] field_timer;
    logic [TIMER_W-1:0] reset_timer;
    logic [TIMER_W-1:0] link_timer;
    logic [TIMER_W-1:0] pulse_timer;
    logic [TIMER_W-1:0] mute_timer;
    logic [TIMER_W-1:0] startup_timer;
    wire logic field_differ = field_a != field_b;
    wire logic link_differ = i_chain_enable && (chain_a != chain_b);
    // a test pulse is any low dip; both channels high means no pulse seen
    wire logic link_high = i_chain_enable && chain_a && chain_b;
    wire logic e36 = field_timer >= TIMER_W'(FIELD_SIM_CYCLES);
    wire logic e39 = reset_timer >= TIMER_W'(RESET_HOLD_CYCLES);
    wire logic e97 = link_timer >= TIMER_W'(LINK_SIM_CYCLES);
    wire logic e98 = pulse_timer >= TIMER_W'(TEST_PULSE_CYCLES);
    wire logic mute_late = mute_timer >= TIMER_W'(MUTE_WINDOW_CYCLES);
    wire logic in_startup = startup_timer < TIMER_W'(STARTUP_CYCLES);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            field_timer <= TIMER_ZERO;
            reset_timer <= TIMER_ZERO;
            link_timer <= TIMER_ZERO;
            pulse_timer <= TIMER_ZERO;
            startup_timer <= TIMER_ZERO;
        end else begin
            field_timer <= sat_inc(field_timer, field_differ);
            reset_timer <= sat_inc(reset_timer, reset_btn);
            link_timer <= sat_inc(link_timer, link_differ);
            pulse_timer <= sat_inc(pulse_timer, link_high);
            startup_timer <= sat_inc(startup_timer, 1'b1);
        end
    end

    // ************************************************************
    // operating mode and locking
    // ************************************************************
    logic [MODE_W-1:0] mode_held;
    logic pol_held;
    logic startup_done;
    logic locked;
    logic [7:0] lock_code;
    wire logic mode_bad = !MODE_VALID_MASK[mode_now];
    wire logic startup_end = in_startup == 1'b0 && !startup_done;
    wire logic pol_changed = startup_done && (mode_pol != pol_held);
    wire logic mode_changed = startup_done && (mode_now != mode_held);
    // polarity reversal also changes the mode lines, so it is checked first
    wire logic [7:0] next_lock_code = pol_changed ? CODE_E41 :
                                      mode_changed ? CODE_E87 :
                                      (startup_end && reset_btn) ? CODE_E80 :
                                      (startup_end && mode_bad) ? CODE_E81 : CODE_NONE;
    wire logic lock_event = next_lock_code != CODE_NONE;

    // a lock only ends with the synchronous restart
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mode_held <= '0;
            pol_held <= 1'b0;
            startup_done <= 1'b0;
            locked <= 1'b0;
            lock_code <= CODE_NONE;
        end else begin
            if (startup_end) begin
                mode_held <= mode_now;
                pol_held <= mode_pol;
                startup_done <= 1'b1;
            end
            if (lock_event && !locked) begin
                locked <= 1'b1;
                lock_code <= next_lock_code;
            end
        end
    end

    // ************************************************************
    // muting supervision
    // ************************************************************
    mute_state_t mute_state;
    mute_state_t next_mute_state;
    logic [7:0] usage_code;
    logic [7:0] next_usage_code;
    logic mute_a_prev;
    logic mute_b_prev;
    wire logic mute_both = mute_a && mute_b;
    wire logic mute_none = !mute_a && !mute_b;
    wire logic both_rose = mute_both && !mute_a_prev && !mute_b_prev;
    wire logic mute_ended = !mute_both;

    always_comb begin
        next_mute_state = mute_state;
        next_usage_code = usage_code;
        unique case (mute_state)
            MUTE_IDLE: begin
                if (both_rose) begin
                    next_mute_state = MUTE_REFUSED;
                    next_usage_code = CODE_U40;
                end else if (!mute_none) begin
                    next_mute_state = MUTE_ONE;
                end
            end
            MUTE_ONE: begin
                if (!i_field_free) begin
                    next_mute_state = MUTE_TRIP;
                    next_usage_code = CODE_U51;
                end else if (mute_both) begin
                    next_mute_state = MUTE_ACTIVE;
                end else if (mute_late) begin
                    next_mute_state = MUTE_REFUSED;
                    next_usage_code = CODE_U41;
                end else if (mute_none) begin
                    next_mute_state = MUTE_IDLE;
                end
            end
            MUTE_ACTIVE: begin
                if (mute_ended && !i_field_free) begin
                    next_mute_state = MUTE_TRIP;
                    next_usage_code = CODE_U43;
                end else if (mute_ended) begin
                    next_mute_state = MUTE_IDLE;
                end
            end
            MUTE_REFUSED: begin
                // outputs follow the field alone until both inputs drop
                if (mute_none) begin
                    next_mute_state = MUTE_IDLE;
                    next_usage_code = CODE_NONE;
                end
            end
            MUTE_TRIP: begin
                if (mute_none && i_field_free) begin
                    next_mute_state = MUTE_IDLE;
                    next_usage_code = CODE_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mute_state <= MUTE_IDLE;
            usage_code <= CODE_NONE;
            mute_a_prev <= 1'b0;
            mute_b_prev <= 1'b0;
            mute_timer <= TIMER_ZERO;
        end else begin
            mute_state <= next_mute_state;
            usage_code <= next_usage_code;
            mute_a_prev <= mute_a;
            mute_b_prev <= mute_b;
            mute_timer <= sat_inc(mute_timer, mute_state == MUTE_ONE);
        end
    end

    // ************************************************************
    // fault collection and display
    // ************************************************************
    wire logic e60 = i_beam_cfg_fault;
    wire logic e61 = i_resp_time_exceeded;
    wire logic e62 = i_teach_active && i_blank_overlap;
    wire logic e92 = i_chan_copy_a_bad;
    wire logic e93 = i_chan_copy_b_bad;
    wire logic ext_fault = locked || e24 || e36 || e39 || e60 || e61 || e62 || e92 || e93 || e97 || e98;
    wire logic [7:0] ext_code = locked ? lock_code :
                                e24 ? CODE_E24 :
                                e36 ? CODE_E36 :
                                e39 ? CODE_E39 :
                                e60 ? CODE_E60 :
                                e61 ? CODE_E61 :
                                e62 ? CODE_E62 :
                                e92 ? CODE_E92 :
                                e93 ? CODE_E93 :
                                e97 ? CODE_E97 :
                                e98 ? CODE_E98 : CODE_NONE;
    wire logic usage_shown = usage_code != CODE_NONE;
    wire logic [7:0] next_class = i_internal_fault ? CLASS_INTERNAL :
                                  ext_fault ? CLASS_EXTERNAL :
                                  usage_shown ? CLASS_USAGE : CLASS_NONE;
    wire logic [7:0] next_code = i_internal_fault ? i_internal_code :
                                 ext_fault ? ext_code : usage_code;
    wire logic muted = mute_state == MUTE_ACTIVE;
    // field may be violated only while muted; trips keep outputs off
    wire logic next_outputs_on = !i_internal_fault && !ext_fault
                                 && mute_state != MUTE_TRIP
                                 && (i_field_free || muted);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_safety_switch_output_one <= 1'b0;
            o_safety_switch_output_two <= 1'b0;
            o_disp_class <= CLASS_NONE;
            o_disp_code <= CODE_NONE;
            o_locked <= 1'b0;
            o_muting_active <= 1'b0;
        end else begin
            o_safety_switch_output_one <= next_outputs_on;
            o_safety_switch_output_two <= next_outputs_on;
            o_disp_class <= next_class;
            o_disp_code <= next_code;
            o_locked <= locked;
            o_muting_active <= muted;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/curtain_supervisor_pkg.sv
package curtain_supervisor_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam longint unsigned CLK_HZ = 64'd50_000_000;
    localparam longint unsigned MS_DIV = 64'd1_000;
    localparam longint unsigned RESET_HOLD_MS = 64'd150_000;   // 2.5 min
    localparam longint unsigned MUTE_WINDOW_MS = 64'd4_000;    // 4 s
    localparam longint unsigned FIELD_SIM_MS = 64'd100;
    localparam longint unsigned LINK_SIM_MS = 64'd100;
    localparam longint unsigned TEST_PULSE_MS = 64'd100;
    localparam longint unsigned STARTUP_MS = 64'd10;
    // every time rounds down to whole cycles by integer division
    localparam longint unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CLK_HZ / MS_DIV;
    localparam longint unsigned MUTE_WINDOW_CYC = MUTE_WINDOW_MS * CLK_HZ / MS_DIV;
    localparam longint unsigned FIELD_SIM_CYC = FIELD_SIM_MS * CLK_HZ / MS_DIV;
    localparam longint unsigned LINK_SIM_CYC = LINK_SIM_MS * CLK_HZ / MS_DIV;
    localparam longint unsigned TEST_PULSE_CYC = TEST_PULSE_MS * CLK_HZ / MS_DIV;
    localparam longint unsigned STARTUP_CYC = STARTUP_MS * CLK_HZ / MS_DIV;
    localparam int TIMER_W = 34;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 34'h0;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 34'h1;

    // ************************************************************
    // pin bundle layout
    // ************************************************************
    localparam int PIN_W = 14;
    localparam int PIN_READBACK = 0;
    localparam int PIN_OTHER_LINE = 1;
    localparam int PIN_FIELD_SEL_A = 2;
    localparam int PIN_FIELD_SEL_B = 3;
    localparam int PIN_RESET_BTN = 4;
    localparam int PIN_MODE_LO = 5;
    localparam int PIN_MODE_HI = 7;
    localparam int PIN_MODE_POL = 8;
    localparam int PIN_CHAIN_A = 9;
    localparam int PIN_CHAIN_B = 10;
    localparam int PIN_MUTE_A = 11;
    localparam int PIN_MUTE_B = 12;
    localparam int PIN_SPARE = 13;
    localparam int MODE_W = 3;
    localparam logic [PIN_W-1:0] PIN_RESET_VAL = 14'h0000;
    // modes 6 and 7 are not selectable
    localparam logic [7:0] MODE_VALID_MASK = 8'h3F;

    // ************************************************************
    // display characters and codes
    // ************************************************************
    localparam logic [7:0] CLASS_NONE = 8'h20;
    localparam logic [7:0] CLASS_INTERNAL = 8'h46;
    localparam logic [7:0] CLASS_EXTERNAL = 8'h45;
    localparam logic [7:0] CLASS_USAGE = 8'h55;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_E24 = 8'h18;
    localparam logic [7:0] CODE_E36 = 8'h24;
    localparam logic [7:0] CODE_E39 = 8'h27;
    localparam logic [7:0] CODE_E41 = 8'h29;
    localparam logic [7:0] CODE_E60 = 8'h3C;
    localparam logic [7:0] CODE_E61 = 8'h3D;
    localparam logic [7:0] CODE_E62 = 8'h3E;
    localparam logic [7:0] CODE_E80 = 8'h50;
    localparam logic [7:0] CODE_E81 = 8'h51;
    localparam logic [7:0] CODE_E87 = 8'h57;
    localparam logic [7:0] CODE_E92 = 8'h5C;
    localparam logic [7:0] CODE_E93 = 8'h5D;
    localparam logic [7:0] CODE_E97 = 8'h61;
    localparam logic [7:0] CODE_E98 = 8'h62;
    localparam logic [7:0] CODE_U40 = 8'h28;
    localparam logic [7:0] CODE_U41 = 8'h29;
    localparam logic [7:0] CODE_U43 = 8'h2B;
    localparam logic [7:0] CODE_U51 = 8'h33;

    typedef enum {MUTE_IDLE, MUTE_ONE, MUTE_ACTIVE, MUTE_REFUSED, MUTE_TRIP} mute_state_t;

endpackage

// ===== rtl/pin_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
    import curtain_supervisor_pkg::*;
    logic [PIN_W-1:0] raw;
    logic [PIN_W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport core_side (output raw, input synced);
endinterface
`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    pin_sync_if.sync_side pins
);
    import curtain_supervisor_pkg::*;

    logic [PIN_W-1:0] stage_one;
    logic [PIN_W-1:0] stage_two;

    // first stage feeds only the second
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            stage_one <= PIN_RESET_VAL;
            stage_two <= PIN_RESET_VAL;
        end else begin
            stage_one <= pins.raw;
            stage_two <= stage_one;
        end
    end

    assign pins.synced = stage_two;
endmodule
`default_nettype wire

// ===== verification/curtain_supervisor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module curtain_supervisor_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_internal_fault,
    input wire logic [7:0] i_internal_code,
    input wire logic i_beam_cfg_fault,
    input wire logic i_resp_time_exceeded,
    input wire logic o_safety_switch_output_one,
    input wire logic o_safety_switch_output_two,
    input wire logic [7:0] o_disp_class,
    input wire logic [7:0] o_disp_code,
    input wire logic o_locked,
    input wire logic o_muting_active
);
    import curtain_supervisor_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // ************
    // display and safety outputs
    // ************
    sequence s_ext_held;
        (o_disp_class == CLASS_EXTERNAL)[*2];
    endsequence
    sequence s_usage_held(logic [7:0] code);
        (o_disp_class == CLASS_USAGE && o_disp_code == code)[*2];
    endsequence
    a_outputs_paired: assert property (o_safety_switch_output_one == o_safety_switch_output_two)
        else $error("safety outputs differ");
    a_internal_shown: assert property (i_internal_fault && !$past(i_rst) |=>
        o_disp_class == CLASS_INTERNAL && o_disp_code == $past(i_internal_code)) else $error("internal code lost");
    a_beam_external: assert property (i_beam_cfg_fault && !i_internal_fault && !$past(i_rst) |=>
        o_disp_class == CLASS_EXTERNAL) else $error("beam fault not shown");
    a_resp_time_off: assert property (i_resp_time_exceeded && !$past(i_rst)
        |-> ##1 !o_safety_switch_output_one) else $error("outputs on after response overrun");
    a_ext_outputs_off: assert property (s_ext_held |-> !o_safety_switch_output_one)
        else $error("outputs on during external fault");
    a_lock_holds: assert property (o_locked |=> o_locked)
        else $error("lock released without restart");
    a_u43_outputs_off: assert property (s_usage_held(CODE_U43) |-> !o_safety_switch_output_one)
        else $error("outputs on after early muting end");
    a_u51_outputs_off: assert property (s_usage_held(CODE_U51) |-> !o_safety_switch_output_one)
        else $error("outputs on with one muting input");
    a_u40_no_muting: assert property (o_disp_class == CLASS_USAGE && o_disp_code == CODE_U40
        |-> !o_muting_active) else $error("muting granted on simultaneous inputs");
endmodule
bind light_curtain_fault_supervisor curtain_supervisor_assertions checks_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_internal_fault(i_internal_fault), .i_internal_code(i_internal_code),
    .i_beam_cfg_fault(i_beam_cfg_fault), .i_resp_time_exceeded(i_resp_time_exceeded),
    .o_safety_switch_output_one(o_safety_switch_output_one), .o_safety_switch_output_two(o_safety_switch_output_two),
    .o_disp_class(o_disp_class), .o_disp_code(o_disp_code), .o_locked(o_locked), .o_muting_active(o_muting_active));
`default_nettype wire

// ===== verification/mute_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module mute_sensor_model (
    input wire logic i_ref_clk,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [7:0] i_gap,
    output var logic o_mute_a = 1'h0,
    output var logic o_mute_b = 1'h0
);
    // gap 8'hFF models a second sensor that never answers
    logic [7:0] count = 8'h00;
    always @(posedge i_ref_clk) begin
        if (i_stop) begin
            o_mute_a <= 1'h0;
            o_mute_b <= 1'h0;
        end else if (i_start && !o_mute_a) begin
            o_mute_a <= 1'h1;
            o_mute_b <= (i_gap == 8'h00);
            count <= 8'h01;
        end else if (o_mute_a && !o_mute_b && i_gap != 8'hFF) begin
            count <= count + 8'h01;
            o_mute_b <= (count == i_gap);
        end
    end
endmodule
`default_nettype wire

// ===== verification/test_light_curtain_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module test_light_curtain_fault_supervisor;
    import curtain_supervisor_pkg::*;
    // ************
    // short counts keep the run brief
    // ************
    localparam int HOLD = 40;
    localparam int WIN = 30;
    localparam int SIM = 20;
    localparam int PULSE = 50;
    localparam int START = 10;
    localparam logic [7:0] CODES [10] = '{CODE_E60, CODE_E61, CODE_E62, CODE_E92, CODE_E93, CODE_E24, CODE_E36,
        CODE_E39, CODE_E97, CODE_E98};
    localparam int LIM [10] = '{4, 4, 4, 4, 4, 8, SIM + 8, HOLD + 8, SIM + 8, PULSE + 8};
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic pol = 1'h0;
    logic boot_btn = 1'h0;
    logic field_free = 1'h1;
    logic int_fault = 1'h0;
    logic start = 1'h0;
    logic stop = 1'h0;
    logic [2:0] mode = 3'h0;
    logic [9:0] flt = 10'h000;
    logic [7:0] gap = 8'h00;
    logic [7:0] int_code = 8'h00;
    logic [7:0] disp_class, disp_code;
    logic mute_a, mute_b, out_one, out_two, locked, muting;
    wire logic btn = flt[7] | boot_btn;
    wire logic chain = flt[8] | flt[9];
    int mismatches = 0;
    int checks = 0;
    always #10 clk = ~clk;
    light_curtain_fault_supervisor #(.RESET_HOLD_CYCLES(HOLD), .MUTE_WINDOW_CYCLES(WIN), .FIELD_SIM_CYCLES(SIM),
        .LINK_SIM_CYCLES(SIM), .TEST_PULSE_CYCLES(PULSE), .STARTUP_CYCLES(START)) dut (
        .i_ref_clk(clk), .i_rst(rst), .i_sig8_drive(flt[5]), .i_sig8_readback(1'h0), .i_other_line(1'h0),
        .i_field_sel_a(flt[6]), .i_field_sel_b(1'h0), .i_reset_btn(btn), .i_mode_sel(mode), .i_mode_polarity(pol),
        .i_chain_enable(chain), .i_chain_a(chain), .i_chain_b(flt[9]), .i_mute_a(mute_a), .i_mute_b(mute_b),
        .i_field_free(field_free), .i_beam_cfg_fault(flt[0]), .i_resp_time_exceeded(flt[1]), .i_teach_active(flt[2]),
        .i_blank_overlap(flt[2]), .i_chan_copy_a_bad(flt[3]), .i_chan_copy_b_bad(flt[4]),
        .i_internal_fault(int_fault), .i_internal_code(int_code), .o_safety_switch_output_one(out_one),
        .o_safety_switch_output_two(out_two), .o_disp_class(disp_class), .o_disp_code(disp_code),
        .o_locked(locked), .o_muting_active(muting));
    mute_sensor_model partner (.i_ref_clk(clk), .i_start(start), .i_stop(stop), .i_gap(gap), .o_mute_a(mute_a),
        .o_mute_b(mute_b));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic msg(input logic [7:0] cls, input logic [7:0] code, input int lim);
        int n;
        n = 0;
        while (n < lim && {disp_class, disp_code} !== {cls, code}) begin
            @(negedge clk);
            n++;
        end
        check({disp_class, disp_code}, {cls, code});
    endtask
    task automatic outs(input logic on);
        repeat (2) @(negedge clk);
        check({14'h0000, out_one, out_two}, {14'h0000, on, on});
    endtask
    task automatic restart(input logic [2:0] m, input logic b);
        rst = 1'h1;
        mode = m;
        boot_btn = b;
        pol = 1'h0;
        repeat (8) @(negedge clk);
        rst = 1'h0;
        repeat (START + 6) @(negedge clk);
        boot_btn = 1'h0;
    endtask
    task automatic t_internal;
        int_code = 8'hA5;
        int_fault = 1'h1;
        msg(CLASS_INTERNAL, 8'hA5, 4);
        int_fault = 1'h0;
        msg(CLASS_NONE, CODE_NONE, 4);
    endtask
    task automatic t_flags;
        for (int i = 0; i < 10; i++) begin
            flt = 10'h001 << i;
            msg(CLASS_EXTERNAL, CODES[i], LIM[i]);
            outs(1'h0);
            flt = 10'h000;
            msg(CLASS_NONE, CODE_NONE, 8);
            outs(1'h1);
        end
    endtask
    task automatic t_mute(input logic [7:0] g, input logic m, input logic viol, input logic [7:0] code, input int lim);
        gap = g;
        start = 1'h1;
        repeat (12) @(negedge clk);
        field_free = !viol;
        check({15'h0000, muting}, {15'h0000, m});
        outs(m | !viol);
        start = !m;
        stop = m;
        msg(CLASS_USAGE, code, lim);
        outs(!viol);
        start = 1'h0;
        stop = 1'h1;
        field_free = 1'h1;
        msg(CLASS_NONE, CODE_NONE, 8);
        stop = 1'h0;
    endtask
    task automatic t_locks;
        pol = 1'h1;
        msg(CLASS_EXTERNAL, CODE_E41, 8);
        flt = 10'h001;
        outs(1'h0);
        check({15'h0000, locked}, 16'h0001);
        msg(CLASS_EXTERNAL, CODE_E41, 1);
        flt = 10'h000;
        restart(3'h0, 1'h0);
        mode = 3'h1;
        msg(CLASS_EXTERNAL, CODE_E87, 8);
        restart(3'h0, 1'h1);
        msg(CLASS_EXTERNAL, CODE_E80, 8);
        restart(3'h6, 1'h0);
        msg(CLASS_EXTERNAL, CODE_E81, 8);
        restart(3'h0, 1'h0);
        msg(CLASS_NONE, CODE_NONE, 8);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        restart(3'h0, 1'h0);
        outs(1'h1);
        t_internal();
        t_flags();
        t_mute(8'h05, 1'h1, 1'h1, CODE_U43, 8);
        t_mute(8'h00, 1'h0, 1'h0, CODE_U40, 8);
        t_mute(8'h28, 1'h0, 1'h0, CODE_U41, WIN + 8);
        t_mute(8'hFF, 1'h0, 1'h1, CODE_U51, 8);
        t_locks();
        report_and_stop();
    end
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
